/* File: prog_fir_pkg.sv */
// Shared constants for the programmable tap filter configuration block
`default_nettype none
package prog_fir_pkg;
  // ---------------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 11;
  localparam int DATA_W = 16;
  localparam int CFG_W = 8;
  localparam logic [ADDR_W-1:0] CFG_ADDR = 11'h400;
  localparam logic [ADDR_W-1:0] TAP0_ADDR = 11'h418;
  localparam logic [ADDR_W-1:0] TAP1_ADDR = 11'h41a;
  localparam logic [ADDR_W-1:0] TAP2_ADDR = 11'h41c;
  localparam logic [CFG_W-1:0] CFG_RST = 8'h00;
  localparam logic [DATA_W-1:0] TAP_RST = 16'h0000;
  localparam logic [DATA_W-1:0] RD_IDLE = 16'h0000;
  // ---------------------------------------------------------------------
  // Field layout of equalizer_config and the tap registers
  // ---------------------------------------------------------------------
  localparam int SHARE_BIT = 6;
  localparam int MERGE_BIT = 5;
  localparam int SCW_MSB = 4;
  localparam int SCW_LSB = 2;
  localparam int SCW_W = SCW_MSB - SCW_LSB + 1;
  localparam int MODE_MSB = 1;
  localparam int MODE_LSB = 0;
  localparam logic [1:0] MODE_ON = 2'h2;
  localparam int COEF_MSB = 11;
  localparam int COEF_W = COEF_MSB + 1;
  // ---------------------------------------------------------------------
  // Coefficient weights: side LSB is 2^(scw-16), centre LSB 2^-11
  // ---------------------------------------------------------------------
  localparam int SIDE_FRAC = 16;
  localparam int CENTER_FRAC = 11;
  localparam int CENTER_SHIFT = SIDE_FRAC - CENTER_FRAC;
endpackage
`default_nettype wire

/* File: smp_if.sv */
// Valid/ready sample stream carried between the block's own modules
`default_nettype none
interface smp_if #(
  parameter int W = 24
);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* File: smp_skid_buf.sv */
// Two-entry valid/ready buffer with registered outputs and ready
`default_nettype none
module smp_skid_buf #(
  parameter int W = 24
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  smp_if.snk in_s,
  smp_if.src out_s
);
  generate
    if (W < 1) begin : g_bad_w
      $error("smp_skid_buf: width must be at least 1");
    end
  endgenerate

  logic [W-1:0] out_data_ff, nxt_out_data;
  logic [W-1:0] skid_data_ff, nxt_skid_data;
  logic out_valid_ff, nxt_out_valid;
  logic skid_valid_ff, nxt_skid_valid;
  logic ready_ff;
  logic in_fire;
  logic out_take;

  assign in_fire = in_s.valid && ready_ff;
  assign out_take = !out_valid_ff || out_s.ready;
  assign in_s.ready = ready_ff;
  assign out_s.valid = out_valid_ff;
  assign out_s.data = out_data_ff;

  // -------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------
  // Ready is registered, so a stall costs one word of room: the skid slot
  always_comb begin
    nxt_out_data = out_data_ff;
    nxt_out_valid = out_valid_ff;
    nxt_skid_data = skid_data_ff;
    nxt_skid_valid = skid_valid_ff;
    if (out_take) begin
      if (skid_valid_ff) begin
        nxt_out_data = skid_data_ff;
        nxt_out_valid = 1'b1;
        nxt_skid_valid = 1'b0;
      end else begin
        nxt_out_data = in_s.data;
        nxt_out_valid = in_fire;
      end
    end else if (in_fire) begin
      nxt_skid_data = in_s.data;
      nxt_skid_valid = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      out_valid_ff <= 1'b0;
      skid_valid_ff <= 1'b0;
      ready_ff <= 1'b0;
    end else begin
      out_valid_ff <= nxt_out_valid;
      skid_valid_ff <= nxt_skid_valid;
      ready_ff <= !nxt_skid_valid;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    out_data_ff <= nxt_out_data;
    skid_data_ff <= nxt_skid_data;
  end

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  a_stall_holds:
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    out_valid_ff && !out_s.ready |=> out_valid_ff && $stable(out_data_ff))
  else $error("buffer output changed during stall");

  a_full_refuses:
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    skid_valid_ff |-> !ready_ff)
  else $error("buffer accepts while full");
endmodule
`default_nettype wire

/* File: prog_fir_cfg.sv */
// Configuration registers, tap storage and 3-tap sample path of the filter
//
// Chosen here: the strobed register port.
`default_nettype none
// Functional notes
// - Share bit set makes channel B use channel A coefficients, else own unless merge bit set.
// - Merge bit set runs both channels as one filter on one stream.
// - Side coefficients weigh 2^(scw-16) per LSB; centre excluded.
// - Mode field 0 disables, 2 enables; 1 and 3 reserved.
// - Tap registers hold signed 12-bit coefficient; bits 15:12 reserved RW.
// - Register 0x418 is first tap, channel A or merged filter.
// - Register 0x41A is second tap, channel A or merged filter.
// - Register 0x41C is third tap, channel A or merged filter.
// - Config register at 0x400 resets to 0x00.
module prog_fir_cfg
  import prog_fir_pkg::*;
#(
  parameter int SMP_W = 12
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [prog_fir_pkg::ADDR_W-1:0] i_addr,
  input wire logic [prog_fir_pkg::DATA_W-1:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [prog_fir_pkg::DATA_W-1:0] o_rd_data,
  input wire logic [prog_fir_pkg::DATA_W-1:0] i_chb_coef0,
  input wire logic [prog_fir_pkg::DATA_W-1:0] i_chb_coef1,
  input wire logic [prog_fir_pkg::DATA_W-1:0] i_chb_coef2,
  input wire logic [SMP_W-1:0] i_smp_a,
  input wire logic [SMP_W-1:0] i_smp_b,
  input wire logic i_smp_valid,
  output logic o_smp_ready,
  output logic [SMP_W-1:0] o_out_a,
  output logic [SMP_W-1:0] o_out_b,
  output logic o_out_valid,
  input wire logic i_out_ready
);
  import prog_fir_pkg::*;

  generate
    if (SMP_W < 2 || SMP_W > 16) begin : g_bad_smp
      $error("prog_fir_cfg: sample width must be 2 to 16");
    end
  endgenerate

  localparam int PROD_W = COEF_W + SMP_W;
  // Headroom for a 7-step side shift plus the three-term sum
  localparam int ACC_W = PROD_W + 10;
  localparam logic signed [ACC_W-1:0] SAT_MAX =
    ACC_W'((64'sd1 <<< (SMP_W - 1)) - 64'sd1);
  localparam logic signed [ACC_W-1:0] SAT_MIN = -SAT_MAX - ACC_W'(1);

  // ---------------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------------
  logic [CFG_W-1:0] cfg_ff;
  logic [DATA_W-1:0] tap0_ff;
  logic [DATA_W-1:0] tap1_ff;
  logic [DATA_W-1:0] tap2_ff;
  logic [DATA_W-1:0] rd_data_ff;
  logic [DATA_W-1:0] rd_mux;
  logic hit_cfg, hit_tap0, hit_tap1, hit_tap2;

  assign hit_cfg = i_addr == CFG_ADDR;
  assign hit_tap0 = i_addr == TAP0_ADDR;
  assign hit_tap1 = i_addr == TAP1_ADDR;
  assign hit_tap2 = i_addr == TAP2_ADDR;

  // Unmapped addresses read as zero and ignore writes
  assign rd_mux = hit_cfg ? {{(DATA_W-CFG_W){1'b0}}, cfg_ff} :
                  hit_tap0 ? tap0_ff :
                  hit_tap1 ? tap1_ff :
                  hit_tap2 ? tap2_ff : RD_IDLE;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cfg_ff <= CFG_RST;
    end else if (i_wr_en && hit_cfg) begin
      cfg_ff <= i_wr_data[CFG_W-1:0];
    end
  end

  // Reserved top bits are stored as written and read back
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      tap0_ff <= TAP_RST;
      tap1_ff <= TAP_RST;
      tap2_ff <= TAP_RST;
    end else if (i_wr_en) begin
      if (hit_tap0) tap0_ff <= i_wr_data;
      if (hit_tap1) tap1_ff <= i_wr_data;
      if (hit_tap2) tap2_ff <= i_wr_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rd_data_ff <= RD_IDLE;
    end else begin
      rd_data_ff <= i_rd_en ? rd_mux : RD_IDLE;
    end
  end

  assign o_rd_data = rd_data_ff;

  // ---------------------------------------------------------------------
  // Configuration decode
  // ---------------------------------------------------------------------
  logic filt_on, share_on, merge_on, b_uses_a;
  logic [SCW_W-1:0] scw;

  // Reserved mode codes behave as disabled
  assign filt_on = cfg_ff[MODE_MSB:MODE_LSB] == MODE_ON;
  assign share_on = cfg_ff[SHARE_BIT];
  assign merge_on = cfg_ff[MERGE_BIT];
  assign scw = cfg_ff[SCW_MSB:SCW_LSB];
  // A merged filter is one filter, so it can only run on the A set
  assign b_uses_a = share_on || merge_on;

  // ---------------------------------------------------------------------
  // Coefficient selection
  // ---------------------------------------------------------------------
  logic signed [COEF_W-1:0] a_c0, a_c1, a_c2;
  logic signed [COEF_W-1:0] b_c0, b_c1, b_c2;

  assign a_c0 = tap0_ff[COEF_MSB:0];
  assign a_c1 = tap1_ff[COEF_MSB:0];
  assign a_c2 = tap2_ff[COEF_MSB:0];
  assign b_c0 = b_uses_a ? a_c0 : i_chb_coef0[COEF_MSB:0];
  assign b_c1 = b_uses_a ? a_c1 : i_chb_coef1[COEF_MSB:0];
  assign b_c2 = b_uses_a ? a_c2 : i_chb_coef2[COEF_MSB:0];

  // ---------------------------------------------------------------------
  // Sample history and tap inputs
  // ---------------------------------------------------------------------
  logic signed [SMP_W-1:0] h_a1_ff, h_a2_ff, h_b1_ff, h_b2_ff;
  logic signed [SMP_W-1:0] a_x0, a_x1, a_x2;
  logic signed [SMP_W-1:0] b_x0, b_x1, b_x2;
  logic in_fire;

  assign in_fire = i_smp_valid && o_smp_ready;

  // Merged stream order per beat: A sample first, then B sample
  assign a_x0 = i_smp_a;
  assign a_x1 = merge_on ? h_b1_ff : h_a1_ff;
  assign a_x2 = merge_on ? h_a1_ff : h_a2_ff;
  assign b_x0 = i_smp_b;
  assign b_x1 = merge_on ? i_smp_a : h_b1_ff;
  assign b_x2 = merge_on ? h_b1_ff : h_b2_ff;

  // History only advances on accepted beats, so stalls keep it intact
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      h_a1_ff <= '0;
      h_a2_ff <= '0;
      h_b1_ff <= '0;
      h_b2_ff <= '0;
    end else if (in_fire) begin
      h_a1_ff <= i_smp_a;
      h_a2_ff <= h_a1_ff;
      h_b1_ff <= i_smp_b;
      h_b2_ff <= h_b1_ff;
    end
  end

  // ---------------------------------------------------------------------
  // Tap arithmetic
  // ---------------------------------------------------------------------
  function automatic logic signed [ACC_W-1:0] acc3(
    input logic signed [COEF_W-1:0] c0,
    input logic signed [COEF_W-1:0] c1,
    input logic signed [COEF_W-1:0] c2,
    input logic signed [SMP_W-1:0] x0,
    input logic signed [SMP_W-1:0] x1,
    input logic signed [SMP_W-1:0] x2,
    input logic [SCW_W-1:0] s
  );
    logic signed [PROD_W-1:0] p0;
    logic signed [PROD_W-1:0] p1;
    logic signed [PROD_W-1:0] p2;
    logic signed [ACC_W-1:0] side;
    logic signed [ACC_W-1:0] ctr;
    p0 = c0 * x0;
    p1 = c1 * x1;
    p2 = c2 * x2;
    // Side taps on a common 2^-16 grid, scaled up by the weight field
    side = (ACC_W'(p0) + ACC_W'(p2)) <<< s;
    ctr = ACC_W'(p1) <<< CENTER_SHIFT;
    return side + ctr;
  endfunction

  function automatic logic [SMP_W-1:0] sat(
    input logic signed [ACC_W-1:0] acc
  );
    logic signed [ACC_W-1:0] q;
    q = acc >>> SIDE_FRAC;
    // Truncating toward minus infinity; no rounding of the result
    if (q > SAT_MAX) begin
      return SAT_MAX[SMP_W-1:0];
    end else if (q < SAT_MIN) begin
      return SAT_MIN[SMP_W-1:0];
    end else begin
      return q[SMP_W-1:0];
    end
  endfunction

  logic signed [ACC_W-1:0] acc_a, acc_b;
  logic [SMP_W-1:0] y_a, y_b;

  assign acc_a = acc3(a_c0, a_c1, a_c2, a_x0, a_x1, a_x2, scw);
  assign acc_b = acc3(b_c0, b_c1, b_c2, b_x0, b_x1, b_x2, scw);
  assign y_a = filt_on ? sat(acc_a) : i_smp_a;
  assign y_b = filt_on ? sat(acc_b) : i_smp_b;

  // ---------------------------------------------------------------------
  // Output buffer
  // ---------------------------------------------------------------------
  smp_if #(.W(2 * SMP_W)) in_s ();
  smp_if #(.W(2 * SMP_W)) out_s ();

  assign in_s.valid = i_smp_valid;
  assign in_s.data = {y_a, y_b};
  assign o_smp_ready = in_s.ready;
  assign out_s.ready = i_out_ready;
  assign o_out_valid = out_s.valid;
  assign o_out_a = out_s.data[2*SMP_W-1:SMP_W];
  assign o_out_b = out_s.data[SMP_W-1:0];

  smp_skid_buf #(.W(2 * SMP_W)) u_buf (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .in_s(in_s),
    .out_s(out_s)
  );

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  a_cfg_reset_val:
  assert property (@(posedge i_ref_clk)
    $past(i_rst) |-> cfg_ff == CFG_RST && !filt_on)
  else $error("config not cleared by reset");

  a_tap_readback:
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_wr_en && hit_tap1 ##1 i_rd_en && hit_tap1 && !i_wr_en
    |=> o_rd_data == $past(i_wr_data, 2))
  else $error("tap register read back differs from write");

  a_mode_decode:
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_wr_en && hit_cfg |=>
      filt_on == ($past(i_wr_data[MODE_MSB:MODE_LSB]) == MODE_ON))
  else $error("filter enable does not follow mode field");

  a_share_coefs:
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    share_on |-> b_c0 == a_c0 && b_c1 == a_c1 && b_c2 == a_c2)
  else $error("shared channel B not on channel A set");

  a_own_coefs:
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !share_on && !merge_on |-> b_c2 == signed'(i_chb_coef2[COEF_MSB:0]))
  else $error("channel B not on its own set");

  a_merge_stream:
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    merge_on && in_fire ##1 in_fire |-> a_x1 == $past(i_smp_b))
  else $error("merged filter lost stream order");

  a_dual_taps:
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    filt_on && !merge_on && a_c1 == '0 && a_c2 == '0 && scw == '0
    |-> acc_a == ACC_W'(signed'(tap0_ff[COEF_MSB:0]) * a_x0))
  else $error("first tap not taken from its register");

  a_side_weight:
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    filt_on && !merge_on && a_c0 == '0 && a_c1 == '0
    |-> acc_a == (ACC_W'(a_c2 * h_a2_ff) <<< scw))
  else $error("side weight shift wrong");

  a_centre_fixed:
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    filt_on && !merge_on && a_c0 == '0 && a_c2 == '0
    |-> acc_a == (ACC_W'(a_c1 * h_a1_ff) <<< CENTER_SHIFT))
  else $error("centre tap weight wrong");

  a_third_tap:
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    filt_on && merge_on && in_fire ##1 in_fire ##1 in_fire
    |-> b_x2 == $past(i_smp_b))
  else $error("third tap not on oldest merged sample");

  a_bypass_pass:
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !filt_on && in_fire && !o_out_valid |=>
      o_out_valid && o_out_a == $past(i_smp_a) && o_out_b == $past(i_smp_b))
  else $error("disabled filter altered samples");

  a_cfg_write_lands:
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_wr_en && hit_cfg |=> cfg_ff == $past(i_wr_data[CFG_W-1:0]))
  else $error("config write not stored");

  a_cfg_holds:
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !(i_wr_en && hit_cfg) |=> $stable(cfg_ff))
  else $error("config changed without a write");

  a_tap0_write:
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_wr_en && hit_tap0 |=> tap0_ff == $past(i_wr_data))
  else $error("first tap write not stored");

  a_tap2_write:
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_wr_en && hit_tap2 |=> tap2_ff == $past(i_wr_data))
  else $error("third tap write not stored");

  a_rd_idle_zero:
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !i_rd_en |=> o_rd_data == RD_IDLE)
  else $error("read data not idle outside a read");

  a_unmapped_read:
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_rd_en && !hit_cfg && !hit_tap0 && !hit_tap1 && !hit_tap2
    |=> o_rd_data == RD_IDLE)
  else $error("unmapped read not zero");

  a_merge_coefs:
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    merge_on |-> b_c0 == a_c0 && b_c1 == a_c1 && b_c2 == a_c2)
  else $error("merged filter not on one coefficient set");

  a_own_first_taps:
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !share_on && !merge_on |-> b_c0 == signed'(i_chb_coef0[COEF_MSB:0])
      && b_c1 == signed'(i_chb_coef1[COEF_MSB:0]))
  else $error("channel B first taps not its own");

  a_hist_holds:
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !in_fire |=> $stable(h_a1_ff) && $stable(h_b1_ff))
  else $error("history moved without a beat");

  a_hist_shifts:
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    in_fire |=> h_a2_ff == $past(h_a1_ff) && h_b2_ff == $past(h_b1_ff))
  else $error("history did not shift on a beat");
endmodule
`default_nettype wire

/* File: conv_core_model.sv */
// Behavioural converter cores that feed sample beats into the filter
`default_nettype none
module conv_core_model (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_smp_ready,
  input wire logic i_gap,
  output logic [11:0] o_smp_a,
  output logic [11:0] o_smp_b,
  output logic o_smp_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] beat_q[$];
  task automatic push(input logic [23:0] beat);
    beat_q.push_back(beat);
  endtask
  initial begin
    o_smp_valid = 1'b0;
    o_smp_a = 12'h000;
    o_smp_b = 12'h000;
  end
  // Idle lines flip every cycle so a stale sample is never mistaken as live
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_smp_valid <= 1'b0;
    end else if (!o_smp_valid || i_smp_ready) begin
      if (beat_q.size() > 0 && !(i_gap && o_smp_valid)) begin
        {o_smp_a, o_smp_b} <= beat_q.pop_front();
        o_smp_valid <= 1'b1;
      end else begin
        o_smp_valid <= 1'b0;
        o_smp_a <= ~o_smp_a;
        o_smp_b <= ~o_smp_b;
      end
    end
  end
endmodule
`default_nettype wire

/* File: prog_fir_cfg_tb.sv */
// Self-checking bench for the filter configuration and tap storage block
`default_nettype none
module prog_fir_cfg_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import prog_fir_pkg::*;
  typedef struct packed {
    logic [7:0] cfg;
    logic [15:0] t0, t1, t2;
    logic stall;
  } row_s;
  logic i_ref_clk, i_rst, i_wr_en, i_rd_en, i_out_ready;
  logic gap, stall, hold, smp_valid, o_smp_ready, o_out_valid;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wr_data, o_rd_data;
  logic [DATA_W-1:0] chb[3];
  logic [DATA_W-1:0] tap[3];
  logic [11:0] smp_a, smp_b, o_out_a, o_out_b;
  logic [11:0] got_a[$], got_b[$], exp_a[$], exp_b[$];
  logic [7:0] cfg;
  int err_count, cmp_count, cycles, ha, hb, hha, hhb;
  logic [11:0] beat_a[4] = '{12'h7ff, 12'h800, 12'h100, 12'hf00};
  logic [11:0] beat_b[4] = '{12'h234, 12'h0ff, 12'h801, 12'h7f0};
  row_s rows[11] = '{
    '{8'h00, 16'h0123, 16'h0456, 16'h0789, 1'b0},
    '{8'h02, 16'h1100, 16'h2400, 16'h3f80, 1'b1},
    '{8'h4e, 16'h0fc0, 16'h0300, 16'h0040, 1'b0},
    '{8'h3a, 16'h0020, 16'h0200, 16'h0ff0, 1'b1},
    '{8'h01, 16'h0400, 16'h0400, 16'h0400, 1'b0},
    '{8'h97, 16'hf400, 16'h0400, 16'h0400, 1'b1},
    '{8'h1a, 16'h07ff, 16'h07ff, 16'h07ff, 1'b0},
    '{8'h02, 16'h0a5c, 16'h0000, 16'h0000, 1'b0},
    '{8'h0e, 16'h0000, 16'h0000, 16'h0c40, 1'b0},
    '{8'h06, 16'h0000, 16'h07f0, 16'h0000, 1'b0},
    '{8'h22, 16'h0300, 16'hfe80, 16'h0100, 1'b0}
  };

  prog_fir_cfg #(.SMP_W(12)) prog_fir_cfg_inst (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
    .o_rd_data(o_rd_data), .i_chb_coef0(chb[0]), .i_chb_coef1(chb[1]),
    .i_chb_coef2(chb[2]), .i_smp_a(smp_a), .i_smp_b(smp_b),
    .i_smp_valid(smp_valid), .o_smp_ready(o_smp_ready),
    .o_out_a(o_out_a), .o_out_b(o_out_b), .o_out_valid(o_out_valid),
    .i_out_ready(i_out_ready));
  conv_core_model conv_core_model_inst (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_smp_ready(o_smp_ready),
    .i_gap(gap), .o_smp_a(smp_a), .o_smp_b(smp_b),
    .o_smp_valid(smp_valid));

  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    i_out_ready <= hold ? 1'b0 : (stall ? ~i_out_ready : 1'b1);
    if (o_out_valid === 1'b1 && i_out_ready === 1'b1) begin
      got_a.push_back(o_out_a);
      got_b.push_back(o_out_b);
    end
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------------
  // Reference arithmetic and checking
  // ---------------------------------------------------------------------
  function automatic int sx(input logic [11:0] v);
    return int'($signed(v));
  endfunction
  function automatic logic [11:0] fir(input int c0, c1, c2, x0, x1, x2, s);
    longint acc;
    acc = (longint'(c0 * x0 + c2 * x2) <<< s);
    acc = acc + (longint'(c1 * x1) <<< CENTER_SHIFT);
    acc = acc >>> SIDE_FRAC;
    if (acc > 2047) acc = 2047;
    if (acc < -2048) acc = -2048;
    return acc[11:0];
  endfunction
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------
  // Register bus and stream tasks
  // ---------------------------------------------------------------------
  // Strobe is left high so a read may follow a write with no gap
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    i_addr <= a;
    i_wr_data <= d;
    i_wr_en <= 1'b1;
    i_rd_en <= 1'b0;
    @(posedge i_ref_clk);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
    i_addr <= a;
    i_rd_en <= 1'b1;
    i_wr_en <= 1'b0;
    @(posedge i_ref_clk);
    i_rd_en <= 1'b0;
    #1 check("read data", o_rd_data, exp);
    @(posedge i_ref_clk);
  endtask
  task automatic do_reset();
    i_rst <= 1'b1;
    i_wr_en <= 1'b0;
    repeat (5) @(posedge i_ref_clk);
    got_a.delete();
    got_b.delete();
    exp_a.delete();
    exp_b.delete();
    {ha, hb, hha, hhb} = '0;
    i_rst <= 1'b0;
  endtask
  task automatic send(input int n);
    int a, b, s;
    int ca[3], cb[3];
    logic on, mg;
    #1;
    on = (cfg[MODE_MSB:MODE_LSB] == MODE_ON);
    mg = cfg[MERGE_BIT];
    s = cfg[SCW_MSB:SCW_LSB];
    for (int k = 0; k < 3; k++) begin
      ca[k] = sx(tap[k][11:0]);
      cb[k] = (cfg[SHARE_BIT] || mg) ? ca[k] : sx(chb[k][11:0]);
    end
    for (int i = 0; i < n; i++) begin
      a = sx(beat_a[i % 4]);
      b = sx(beat_b[i % 4]);
      if (!on) begin
        exp_a.push_back(beat_a[i % 4]);
        exp_b.push_back(beat_b[i % 4]);
      end else if (mg) begin
        exp_a.push_back(fir(ca[0], ca[1], ca[2], a, hb, ha, s));
        exp_b.push_back(fir(ca[0], ca[1], ca[2], b, a, hb, s));
      end else begin
        exp_a.push_back(fir(ca[0], ca[1], ca[2], a, ha, hha, s));
        exp_b.push_back(fir(cb[0], cb[1], cb[2], b, hb, hhb, s));
      end
      {hha, ha, hhb, hb} = {ha, a, hb, b};
      conv_core_model_inst.push({beat_a[i % 4], beat_b[i % 4]});
    end
  endtask
  task automatic drain(input int n);
    int w;
    w = 0;
    while (got_a.size() < n && w < 300) begin
      @(posedge i_ref_clk);
      w++;
    end
    check("beats out", 16'(got_a.size()), 16'(n));
    while (got_a.size() > 0 && exp_a.size() > 0) begin
      check("out a", got_a.pop_front(), exp_a.pop_front());
      check("out b", got_b.pop_front(), exp_b.pop_front());
    end
  endtask

  initial begin
    {i_rst, i_wr_en, i_rd_en, i_out_ready} = 4'h8;
    {gap, stall, hold} = 3'h0;
    i_addr = '0;
    i_wr_data = '0;
    chb = '{16'h0000, 16'h0000, 16'h0000};
    {err_count, cmp_count, cycles} = '0;
    @(posedge i_ref_clk);
    for (int r = 0; r < 11; r++) begin
      do_reset();
      cfg = rows[r].cfg;
      tap = '{rows[r].t0, rows[r].t1, rows[r].t2};
      chb <= '{rows[r].t2, rows[r].t0, rows[r].t1};
      gap <= rows[r].stall;
      stall <= rows[r].stall;
      wr(CFG_ADDR, {8'h00, cfg});
      wr(TAP0_ADDR, tap[0]);
      wr(TAP1_ADDR, tap[1]);
      wr(TAP2_ADDR, tap[2]);
      rd(CFG_ADDR, {8'h00, cfg});
      rd(TAP0_ADDR, tap[0]);
      rd(TAP1_ADDR, tap[1]);
      rd(TAP2_ADDR, tap[2]);
      send(6);
      drain(6);
    end
    // Reset values, unmapped place, write then read back to back
    do_reset();
    rd(CFG_ADDR, {8'h00, CFG_RST});
    rd(TAP0_ADDR, TAP_RST);
    rd(TAP1_ADDR, TAP_RST);
    rd(TAP2_ADDR, TAP_RST);
    rd(11'h402, RD_IDLE);
    wr(11'h402, 16'h00ff);
    rd(CFG_ADDR, 16'h0000);
    wr(TAP1_ADDR, 16'h5a5a);
    rd(TAP1_ADDR, 16'h5a5a);
    // Downstream stall: buffer fills, refuses, then drains in order
    cfg = 8'h02;
    tap = '{16'h0100, 16'h0400, 16'h0f00};
    {gap, stall} <= 2'h0;
    wr(CFG_ADDR, {8'h00, cfg});
    wr(TAP0_ADDR, tap[0]);
    wr(TAP1_ADDR, tap[1]);
    wr(TAP2_ADDR, tap[2]);
    i_wr_en <= 1'b0;
    hold <= 1'b1;
    send(5);
    repeat (10) @(posedge i_ref_clk);
    check("input ready", 16'(o_smp_ready), 16'h0000);
    hold <= 1'b0;
    drain(5);
    give_verdict();
  end
endmodule
`default_nettype wire
